// ==== design/vti_csr.sv ====
/*
 * apb register bank for output video timing fields and the error interrupt pin.
 * assumes error events and pll lock arrive asynchronously from the packet
 * processor and pll; the timing/pattern logic downstream reads the struct.
 */
// Implementation choice: the APB slave port.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - vsync width is ten bits, low and high registers
// - single mode feeds channel a, dual feeds both
// - horizontal back porch from eight-bit register
// - vertical back porch used for test pattern
// - horizontal front porch used for test pattern
// - vertical front porch used for test pattern
// - pattern bit makes internal test pattern output
// - interrupt pin undriven while output enable clear
// - pin high when enabled flag also unmasked
// - mask bits 7,6,5 gate sync, checksum, uncorrectable
// - mask bits 4,3 gate corrected, protocol errors
// - errors set flags, write one clears them
// - mask bits 2,0 gate leader, pll unlock
//////////////////////////////////////////////////////////////////////////////
module vti_csr
   import vti_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [VTI_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // error events: sync, checksum, uncorrectable, corrected, protocol, leader
   input wire logic [5:0] err_event,
   input wire logic pll_locked,
   // timing fields to the output stage
   output vti_timing_t timing,
   // interrupt pin
   output logic irq_out,
   output logic irq_oe_n
);
   typedef enum {
      VTI_IDLE,
      VTI_ACK
   } vti_bus_state_t;

   // flag set when an aligned word address indexes a mapped register
   function automatic logic vti_mapped(input logic [VTI_ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      return (a[1:0] == 2'h0) && (i == VTI_IDX_MODE || i == VTI_IDX_VSW_LO ||
         i == VTI_IDX_VSW_HI || i == VTI_IDX_HBP || i == VTI_IDX_VBP ||
         i == VTI_IDX_HFP || i == VTI_IDX_VFP || i == VTI_IDX_PAT ||
         i == VTI_IDX_IRQ_CTL || i == VTI_IDX_IRQ_MASK || i == VTI_IDX_IRQ_STAT);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // synchronised event inputs
   logic [6:0] ev_sync;
   vti_sync #(.WIDTH(7)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pce(pce),
      .async_in({err_event, pll_locked}),
      .sync_out(ev_sync)
   );

   logic lock_prev_reg;
   logic lock_prev_next;
   logic [7:0] set_vec;

   always_comb begin
      lock_prev_next = pce ? ev_sync[0] : lock_prev_reg;
      set_vec = '0;
      set_vec[7:VTI_ERR_LSB] = ev_sync[6:1];
      set_vec[VTI_PLL_POS] = lock_prev_reg & ~ev_sync[0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_prev_reg <= 1'b0;
      end else begin
         lock_prev_reg <= lock_prev_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // apb handshake: one wait state; read data latched as pready rises, write applied at the edge leaving ack
   vti_bus_state_t bus_reg;
   vti_bus_state_t bus_next;
   logic pready_next;
   logic pslverr_next;
   logic [31:0] prdata_next;
   logic do_write;
   logic [7:0] idx;

   assign idx = paddr[9:2];
   assign do_write = pce && (bus_reg == VTI_ACK) && psel && penable && pwrite &&
      vti_mapped(paddr);

   // register storage
   logic [7:0] mode_reg;
   logic [7:0] vsw_lo_reg;
   logic [7:0] vsw_hi_reg;
   logic [7:0] hbp_reg;
   logic [7:0] vbp_reg;
   logic [7:0] hfp_reg;
   logic [7:0] vfp_reg;
   logic [7:0] pat_reg;
   logic [7:0] irq_ctl_reg;
   logic [7:0] irq_mask_reg;
   logic [7:0] irq_stat_reg;
   logic [7:0] mode_next;
   logic [7:0] vsw_lo_next;
   logic [7:0] vsw_hi_next;
   logic [7:0] hbp_next;
   logic [7:0] vbp_next;
   logic [7:0] hfp_next;
   logic [7:0] vfp_next;
   logic [7:0] pat_next;
   logic [7:0] irq_ctl_next;
   logic [7:0] irq_mask_next;
   logic [7:0] irq_stat_next;
   logic [7:0] rd_byte;

   always_comb begin
      case (idx)
         VTI_IDX_MODE: rd_byte = mode_reg;
         VTI_IDX_VSW_LO: rd_byte = vsw_lo_reg;
         VTI_IDX_VSW_HI: rd_byte = vsw_hi_reg;
         VTI_IDX_HBP: rd_byte = hbp_reg;
         VTI_IDX_VBP: rd_byte = vbp_reg;
         VTI_IDX_HFP: rd_byte = hfp_reg;
         VTI_IDX_VFP: rd_byte = vfp_reg;
         VTI_IDX_PAT: rd_byte = pat_reg;
         VTI_IDX_IRQ_CTL: rd_byte = irq_ctl_reg;
         VTI_IDX_IRQ_MASK: rd_byte = irq_mask_reg;
         VTI_IDX_IRQ_STAT: rd_byte = irq_stat_reg;
         default: rd_byte = 8'h00;
      endcase
   end

   always_comb begin
      bus_next = bus_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      prdata_next = prdata;
      if (pce) begin
         case (bus_reg)
            VTI_IDLE: begin
               if (psel && penable) begin
                  bus_next = VTI_ACK;
                  pready_next = 1'b1;
                  pslverr_next = ~vti_mapped(paddr);
                  prdata_next = {24'h000000, vti_mapped(paddr) ? rd_byte : 8'h00};
               end
            end
            VTI_ACK: begin
               bus_next = VTI_IDLE;
            end
            default: begin
               bus_next = VTI_IDLE;
            end
         endcase
      end else begin
         pready_next = pready;
         pslverr_next = pslverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_reg <= VTI_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         bus_reg <= bus_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
         prdata <= prdata_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // register updates; unused bits are masked off on write
   function automatic logic [7:0] vti_upd(input logic [7:0] cur, input logic hit,
      input logic [7:0] wd, input logic [7:0] bits);
      return hit ? (wd & bits) : cur;
   endfunction

   logic [7:0] wd;
   logic [7:0] clr_vec;
   assign wd = pwdata[7:0];

   always_comb begin
      mode_next = vti_upd(mode_reg, do_write && idx == VTI_IDX_MODE, wd, VTI_MODE_BITS);
      vsw_lo_next = vti_upd(vsw_lo_reg, do_write && idx == VTI_IDX_VSW_LO, wd, 8'hff);
      vsw_hi_next = vti_upd(vsw_hi_reg, do_write && idx == VTI_IDX_VSW_HI, wd,
         VTI_VSW_HI_BITS);
      hbp_next = vti_upd(hbp_reg, do_write && idx == VTI_IDX_HBP, wd, 8'hff);
      vbp_next = vti_upd(vbp_reg, do_write && idx == VTI_IDX_VBP, wd, 8'hff);
      hfp_next = vti_upd(hfp_reg, do_write && idx == VTI_IDX_HFP, wd, 8'hff);
      vfp_next = vti_upd(vfp_reg, do_write && idx == VTI_IDX_VFP, wd, 8'hff);
      pat_next = vti_upd(pat_reg, do_write && idx == VTI_IDX_PAT, wd, VTI_PAT_BITS);
      irq_ctl_next = vti_upd(irq_ctl_reg, do_write && idx == VTI_IDX_IRQ_CTL, wd,
         VTI_IRQ_CTL_BITS);
      irq_mask_next = vti_upd(irq_mask_reg, do_write && idx == VTI_IDX_IRQ_MASK, wd,
         VTI_IRQ_SRC_BITS);
      clr_vec = (do_write && idx == VTI_IDX_IRQ_STAT) ? wd : 8'h00;
      // a new event in the clearing cycle survives: set beats clear
      irq_stat_next = pce ? (((irq_stat_reg & ~clr_vec) | set_vec) & VTI_IRQ_SRC_BITS)
         : irq_stat_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= VTI_MODE_RST;
         vsw_lo_reg <= VTI_TIMING_RST;
         vsw_hi_reg <= VTI_TIMING_RST;
         hbp_reg <= VTI_TIMING_RST;
         vbp_reg <= VTI_TIMING_RST;
         hfp_reg <= VTI_TIMING_RST;
         vfp_reg <= VTI_TIMING_RST;
         pat_reg <= VTI_PAT_RST;
         irq_ctl_reg <= VTI_IRQ_CTL_RST;
         irq_mask_reg <= VTI_IRQ_MASK_RST;
         irq_stat_reg <= VTI_IRQ_STAT_RST;
      end else begin
         mode_reg <= mode_next;
         vsw_lo_reg <= vsw_lo_next;
         vsw_hi_reg <= vsw_hi_next;
         hbp_reg <= hbp_next;
         vbp_reg <= vbp_next;
         hfp_reg <= hfp_next;
         vfp_reg <= vfp_next;
         pat_reg <= pat_next;
         irq_ctl_reg <= irq_ctl_next;
         irq_mask_reg <= irq_mask_next;
         irq_stat_reg <= irq_stat_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs, registered one cycle after the source registers
   vti_timing_t timing_next;
   logic irq_out_next;
   logic irq_oe_n_next;

   always_comb begin
      timing_next = timing;
      irq_out_next = irq_out;
      irq_oe_n_next = irq_oe_n;
      if (pce) begin
         timing_next.vsync_width = {vsw_hi_reg[1:0], vsw_lo_reg};
         timing_next.horiz_back_porch = hbp_reg;
         timing_next.vert_back_porch = vbp_reg;
         timing_next.horiz_front_porch = hfp_reg;
         timing_next.vert_front_porch = vfp_reg;
         timing_next.pattern_generator_on = pat_reg[VTI_PAT_ON_POS];
         timing_next.apply_channel_a = 1'b1;
         timing_next.apply_channel_b = ~mode_reg[VTI_SINGLE_CH_POS];
         // level, held while enabled and any unmasked flag stays set
         irq_out_next = irq_ctl_reg[VTI_IRQ_EN_POS] &
            (|(irq_stat_reg & irq_mask_reg));
         irq_oe_n_next = ~irq_ctl_reg[VTI_IRQ_EN_POS];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing <= '0;
         irq_out <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         timing <= timing_next;
         irq_out <= irq_out_next;
         irq_oe_n <= irq_oe_n_next;
      end
   end
endmodule
`default_nettype wire

// ==== design/vti_pkg.sv ====
/*
 * constants and carrier types for the video timing and interrupt register bank.
 * assumes a 32-bit apb slave with word-aligned registers, byte address = 4 * index.
 */
`default_nettype none
package vti_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] VTI_IDX_MODE = 8'h18;
   localparam logic [7:0] VTI_IDX_VSW_LO = 8'h30;
   localparam logic [7:0] VTI_IDX_VSW_HI = 8'h31;
   localparam logic [7:0] VTI_IDX_HBP = 8'h34;
   localparam logic [7:0] VTI_IDX_VBP = 8'h36;
   localparam logic [7:0] VTI_IDX_HFP = 8'h38;
   localparam logic [7:0] VTI_IDX_VFP = 8'h3a;
   localparam logic [7:0] VTI_IDX_PAT = 8'h3c;
   localparam logic [7:0] VTI_IDX_IRQ_CTL = 8'he0;
   localparam logic [7:0] VTI_IDX_IRQ_MASK = 8'he1;
   localparam logic [7:0] VTI_IDX_IRQ_STAT = 8'he5;
   localparam int VTI_ADDR_W = 10;

   // writable bits of each register
   localparam logic [7:0] VTI_MODE_BITS = 8'h10;
   localparam logic [7:0] VTI_VSW_HI_BITS = 8'h03;
   localparam logic [7:0] VTI_PAT_BITS = 8'h10;
   localparam logic [7:0] VTI_IRQ_CTL_BITS = 8'h01;
   localparam logic [7:0] VTI_IRQ_SRC_BITS = 8'hfd;

   // field positions
   localparam int VTI_SINGLE_CH_POS = 4;
   localparam int VTI_PAT_ON_POS = 4;
   localparam int VTI_IRQ_EN_POS = 0;
   localparam int VTI_PLL_POS = 0;
   localparam int VTI_ERR_LSB = 2;

   // reset values
   localparam logic [7:0] VTI_TIMING_RST = 8'h00;
   localparam logic [7:0] VTI_MODE_RST = 8'h00;
   localparam logic [7:0] VTI_PAT_RST = 8'h00;
   localparam logic [7:0] VTI_IRQ_CTL_RST = 8'h00;
   localparam logic [7:0] VTI_IRQ_MASK_RST = 8'h00;
   localparam logic [7:0] VTI_IRQ_STAT_RST = 8'h01;

   typedef struct packed {
      logic [9:0] vsync_width;
      logic [7:0] horiz_back_porch;
      logic [7:0] vert_back_porch;
      logic [7:0] horiz_front_porch;
      logic [7:0] vert_front_porch;
      logic pattern_generator_on;
      logic apply_channel_a;
      logic apply_channel_b;
   } vti_timing_t;
endpackage
`default_nettype wire

// ==== design/vti_sync.sv ====
/*
 * two-stage synchroniser for a vector of asynchronous levels.
 * assumes each bit is an independent level; no bus coherency is given.
 */
`default_nettype none
module vti_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb begin
      meta_next = pce ? async_in : meta_reg;
      sync_next = pce ? meta_reg : sync_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ==== tb/video_timing_irq_csr_test.sv ====
/*
 * self-checking bench for the timing and interrupt register bank.
 * assumes the apb slave answers before the watchdog expires; pce drops only while idle.
 */
`default_nettype none
module video_timing_irq_csr_test
   import vti_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, pce = 1, psel = 0, penable = 0, pwrite = 0, pll_locked = 1;
   logic [9:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [5:0] err_event = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq_out, irq_oe_n, er;
   vti_timing_t timing;
   int n_errors = 0, total_checks = 0, i;
   integer seed = 32'h80dbd220;
   logic [7:0] m;
   logic [7:0] mdl [256];
   logic [7:0] regs [11] = '{VTI_IDX_MODE, VTI_IDX_VSW_LO, VTI_IDX_VSW_HI, VTI_IDX_HBP,
      VTI_IDX_VBP, VTI_IDX_HFP, VTI_IDX_VFP, VTI_IDX_PAT, VTI_IDX_IRQ_CTL, VTI_IDX_IRQ_MASK,
      VTI_IDX_IRQ_STAT};
   always #2.5 pclk = ~pclk;
   vti_csr dut_u(.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .err_event(err_event), .pll_locked(pll_locked), .timing(timing),
      .irq_out(irq_out), .irq_oe_n(irq_oe_n));
   //////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [7:0] wmask(input logic [7:0] idx);
      case (idx)
         VTI_IDX_MODE: return VTI_MODE_BITS;
         VTI_IDX_VSW_HI: return VTI_VSW_HI_BITS;
         VTI_IDX_PAT: return VTI_PAT_BITS;
         VTI_IDX_IRQ_CTL: return VTI_IRQ_CTL_BITS;
         VTI_IDX_IRQ_MASK: return VTI_IRQ_SRC_BITS;
         default: return 8'hff;
      endcase
   endfunction
   // status expectations are kept by the caller, the rw1c side effect differs
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1;
      // no cycle count assumed; a hung slave is left to the watchdog
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (w && idx != VTI_IDX_IRQ_STAT) mdl[idx] = wd & wmask(idx);
   endtask
   task rdchk(input logic [7:0] idx);
      apb(0, idx, 8'h00);
      chk(rd, {24'h0, mdl[idx]});
      chk(32'(er), 32'h0);
   endtask
   task idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      foreach (mdl[k]) mdl[k] = 8'h00;
      mdl[VTI_IDX_IRQ_STAT] = VTI_IRQ_STAT_RST;
      idle(3);
      presetn <= 1;
      chk(32'(irq_oe_n), 32'h1);
      foreach (regs[k]) rdchk(regs[k]);
      $display("reset test done");
      for (i = 0; i < 10; i++) apb(1, regs[i], 8'hff);
      repeat (40) begin
         m = regs[{$random(seed)} % 10];
         apb(1, m, 8'($random(seed)));
         rdchk(m);
      end
      chk(32'(timing.vsync_width), {22'h0, mdl[VTI_IDX_VSW_HI][1:0], mdl[VTI_IDX_VSW_LO]});
      chk(32'(timing.horiz_back_porch), 32'(mdl[VTI_IDX_HBP]));
      chk(32'(timing.vert_back_porch), 32'(mdl[VTI_IDX_VBP]));
      chk(32'(timing.horiz_front_porch), 32'(mdl[VTI_IDX_HFP]));
      chk(32'(timing.vert_front_porch), 32'(mdl[VTI_IDX_VFP]));
      chk(32'(timing.pattern_generator_on), 32'(mdl[VTI_IDX_PAT][4]));
      apb(1, 8'h40, 8'h5a);
      apb(0, 8'h40, 8'h00);
      chk(rd, 32'h0);
      chk(32'(er), 32'h1);
      for (i = 0; i < 2; i++) begin
         apb(1, VTI_IDX_MODE, 8'(i << 4));
         rdchk(VTI_IDX_MODE);
         chk(32'({timing.apply_channel_a, timing.apply_channel_b}), 32'(2 + 1 - i));
      end
      $display("register test done");
      apb(1, VTI_IDX_IRQ_STAT, 8'h01);
      mdl[VTI_IDX_IRQ_STAT] = 8'h00;
      rdchk(VTI_IDX_IRQ_STAT);
      // a frozen synchroniser must miss an event that comes and goes while pce is low
      pce <= 0;
      err_event[0] <= 1;
      idle(2);
      err_event[0] <= 0;
      idle(2);
      pce <= 1;
      rdchk(VTI_IDX_IRQ_STAT);
      apb(1, VTI_IDX_IRQ_CTL, 8'h01);
      for (i = 0; i < 7; i++) begin
         m = (i < 6) ? 8'(1 << (i + 2)) : 8'h01;
         apb(1, VTI_IDX_IRQ_MASK, 8'h00);
         if (i < 6) err_event[i] <= 1;
         else pll_locked <= 0;
         idle(2);
         err_event <= '0;
         pll_locked <= 1;
         idle(6);
         mdl[VTI_IDX_IRQ_STAT] = m;
         rdchk(VTI_IDX_IRQ_STAT);
         chk({30'h0, irq_oe_n, irq_out}, 32'h0);
         apb(1, VTI_IDX_IRQ_MASK, m);
         idle(3);
         chk(32'(irq_out), 32'h1);
         apb(1, VTI_IDX_IRQ_STAT, 8'h00);
         rdchk(VTI_IDX_IRQ_STAT);
         chk(32'(irq_out), 32'h1);
         apb(1, VTI_IDX_IRQ_STAT, m);
         mdl[VTI_IDX_IRQ_STAT] = 8'h00;
         idle(3);
         chk(32'(irq_out), 32'h0);
      end
      apb(1, VTI_IDX_IRQ_CTL, 8'h00);
      idle(3);
      chk(32'(irq_oe_n), 32'h1);
      $display("interrupt test done");
      conclude();
   end
   initial begin
      idle(20000);
      n_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
`default_nettype wire

// ==== tb/vti_csr_assertions.sv ====
/*
 * port-level checker for the timing and interrupt register bank.
 * assumes pce held high, so register writes reach the outputs two edges later.
 */
`default_nettype none
module vti_csr_chk
   import vti_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [VTI_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // outputs
   input wire vti_timing_t timing,
   input wire logic irq_oe_n
);
   logic wr;
   assign wr = psel && penable && pready && pwrite && pce;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   //////////////////////////////////////////////////////////////////////////
   a_vsync_low: assert property (wr && paddr == {VTI_IDX_VSW_LO, 2'b00}
      |-> ##2 timing.vsync_width[7:0] == $past(pwdata[7:0], 2)) else $error("vsync low bad");
   a_vsync_high: assert property (wr && paddr == {VTI_IDX_VSW_HI, 2'b00}
      |-> ##2 timing.vsync_width[9:8] == $past(pwdata[1:0], 2)) else $error("vsync high bad");
   a_chan_b_mode: assert property (wr && paddr == {VTI_IDX_MODE, 2'b00}
      |-> ##2 timing.apply_channel_b == !$past(pwdata[4], 2)) else $error("channel b bad");
   a_chan_a_on: assert property ($past(presetn) |-> timing.apply_channel_a)
      else $error("channel a off");
   a_hbp_apply: assert property (wr && paddr == {VTI_IDX_HBP, 2'b00}
      |-> ##2 timing.horiz_back_porch == $past(pwdata[7:0], 2)) else $error("hbp bad");
   a_vbp_apply: assert property (wr && paddr == {VTI_IDX_VBP, 2'b00}
      |-> ##2 timing.vert_back_porch == $past(pwdata[7:0], 2)) else $error("vbp bad");
   a_hfp_apply: assert property (wr && paddr == {VTI_IDX_HFP, 2'b00}
      |-> ##2 timing.horiz_front_porch == $past(pwdata[7:0], 2)) else $error("hfp bad");
   a_vfp_apply: assert property (wr && paddr == {VTI_IDX_VFP, 2'b00}
      |-> ##2 timing.vert_front_porch == $past(pwdata[7:0], 2)) else $error("vfp bad");
   a_pattern_on: assert property (wr && paddr == {VTI_IDX_PAT, 2'b00}
      |-> ##2 timing.pattern_generator_on == $past(pwdata[4], 2)) else $error("pattern bad");
   a_oe_follow: assert property (wr && paddr == {VTI_IDX_IRQ_CTL, 2'b00}
      |-> ##2 irq_oe_n == !$past(pwdata[0], 2)) else $error("pin enable bad");
   a_read_upper: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read upper bits set");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind vti_csr vti_csr_chk chk_u(.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .timing(timing), .irq_oe_n(irq_oe_n));
`default_nettype wire
